// ===== rtl/gpio_irq_status_enable.sv
`timescale 1ns/1ps
module gpio_irq_status_enable #(
	parameter int PINS = pin_event_pkg::PIN_COUNT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [pin_event_pkg::ADDR_W-1:0] addr,
	input wire logic [pin_event_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [pin_event_pkg::DATA_W-1:0] rd_data_q,
	// pads
	input wire logic [PINS-1:0] pin_level,
	// interrupt to processor 0
	output logic irq_cpu0_q
);
	import pin_event_pkg::*;

	localparam int RAW_W = EVT_BITS * PINS; // packed event width
	localparam int WORDS = 4; // raw status words
	localparam int ALL_W = WORDS * DATA_W; // padded event width

	// raw event vector from the detector
	logic [RAW_W-1:0] events;
	// events padded to four whole words
	logic [ALL_W-1:0] events_all;
	// clear requests, padded and trimmed
	logic [ALL_W-1:0] clr_all;
	logic [RAW_W-1:0] edge_clr;

	// enable and force words of processor 0
	logic [DATA_W-1:0] enable_q;
	logic [DATA_W-1:0] enable_d;
	logic [DATA_W-1:0] force_q;
	logic [DATA_W-1:0] force_d;

	// interrupt next value
	logic irq_d;

	// address decode strobes
	logic hit_raw0;
	logic hit_raw1;
	logic hit_raw2;
	logic hit_raw3;
	logic hit_en;
	logic hit_frc;

	// views of each raw word
	logic [DATA_W-1:0] raw0;
	logic [DATA_W-1:0] raw1;
	logic [DATA_W-1:0] raw2;
	logic [DATA_W-1:0] raw3;

	// read path
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rd_data_d;

	// edge bits only, clears never touch level bits
	function automatic logic [DATA_W-1:0] edge_only(input logic [DATA_W-1:0] w);
		edge_only = w & EDGE_BITS_MASK;
	endfunction

	// write-one-to-clear request for one raw word
	function automatic logic [DATA_W-1:0] clr_word(input logic hit, input logic we,
		input logic [DATA_W-1:0] w);
		clr_word = (hit && we) ? edge_only(w) : '0;
	endfunction

	// detector keeps the sticky edges and shows the live levels
	pin_event_detect #(
		.PINS(PINS)
	) u_detect (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_level(pin_level),
		.edge_clr(edge_clr),
		.events(events)
	);

	// padding above the last pin reads as zero
	assign events_all = {{(ALL_W-RAW_W){1'b0}}, events};

	// one word per eight pins, lowest pin in the lowest nibble
	assign raw0 = events_all[0*DATA_W +: DATA_W];
	assign raw1 = events_all[1*DATA_W +: DATA_W];
	assign raw2 = events_all[2*DATA_W +: DATA_W];
	assign raw3 = events_all[3*DATA_W +: DATA_W] & RAW_LAST_MASK;

	// address decode
	assign hit_raw0 = (addr == RAW_PINS_0_7_OFS);
	assign hit_raw1 = (addr == RAW_PINS_8_15_OFS);
	assign hit_raw2 = (addr == RAW_PINS_16_23_OFS);
	assign hit_raw3 = (addr == RAW_PINS_24_29_OFS);
	assign hit_en = (addr == CPU0_ENABLE_0_7_OFS);
	assign hit_frc = (addr == CPU0_FORCE_0_7_OFS);

	// writes to raw words clear edges only; level bits drop out
	assign clr_all = {
		clr_word(hit_raw3, wr_en, wr_data & RAW_LAST_MASK),
		clr_word(hit_raw2, wr_en, wr_data),
		clr_word(hit_raw1, wr_en, wr_data),
		clr_word(hit_raw0, wr_en, wr_data)
	};
	assign edge_clr = clr_all[RAW_W-1:0];

	// enable and force words take the whole write
	assign enable_d = (wr_en && hit_en) ? wr_data : enable_q;
	assign force_d = (wr_en && hit_frc) ? wr_data : force_q;

	// any enabled event of pins 0-7, raw or forced
	assign irq_d = |(enable_q & (raw0 | force_q));

	// read select, unmapped addresses read zero
	assign rd_mux = hit_raw0 ? raw0 :
		hit_raw1 ? raw1 :
		hit_raw2 ? raw2 :
		hit_raw3 ? raw3 :
		hit_en ? enable_q :
		hit_frc ? force_q :
		RDATA_RESET;

	// data stand only in the cycle after the read strobe
	assign rd_data_d = rd_en ? rd_mux : RDATA_RESET;

	// software-written words
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable_q <= ENABLE_RESET;
			force_q <= FORCE_RESET;
		end else begin
			enable_q <= enable_d;
			force_q <= force_d;
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data_q <= RDATA_RESET;
			irq_cpu0_q <= 1'b0;
		end else begin
			rd_data_q <= rd_data_d;
			irq_cpu0_q <= irq_d;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// read of the pins 8-15 word returns it next cycle
	a_raw1_read: assert property (rd_en && addr == RAW_PINS_8_15_OFS |=>
		rd_data_q == $past(raw1))
		else $error("pins 8-15 word read wrong");

	// read of the pins 16-23 word returns it next cycle
	a_raw2_read: assert property (rd_en && addr == RAW_PINS_16_23_OFS |=>
		rd_data_q == $past(events_all[2*DATA_W +: DATA_W]))
		else $error("pins 16-23 word read wrong");

	// top byte of the last raw word reads zero
	a_raw3_top: assert property (rd_en && addr == RAW_PINS_24_29_OFS |=>
		rd_data_q[31:24] == 8'h00 && rd_data_q[23:0] == $past(events[119:96]))
		else $error("pins 24-29 word wrong");

	// rising pin 8 shows in bit 3 of its nibble
	a_nibble_rise: assert property (!pin_level[8] ##1 pin_level[8] |=> raw1[3])
		else $error("pin 8 rise not in bit 3");

	// a set edge bit holds while no clear arrives
	a_edge_hold: assert property (raw1[7] && !(wr_en && hit_raw1 && wr_data[7]) |=>
		raw1[7])
		else $error("edge bit lost without clear");

	// writing one clears an edge bit when no new edge arrives
	a_edge_clear: assert property (wr_en && hit_raw2 && wr_data[2]
		&& !(pin_level[16] == 1'b0 && $past(pin_level[16]) == 1'b1) |=> !raw2[2])
		else $error("edge bit not cleared");

	// level bits follow the pad directly
	a_level_live: assert property (raw1[1] == pin_level[8] && raw1[0] == !pin_level[8])
		else $error("level bits do not follow pad");

	// enable word takes a write and holds it
	a_enable_write: assert property (wr_en && addr == CPU0_ENABLE_0_7_OFS |=>
		enable_q == $past(wr_data) ##1 (enable_q == $past(enable_q) || $past(wr_en)))
		else $error("enable word did not store");

	// force with enable raises the interrupt two cycles after the write
	a_force_irq: assert property (wr_en && addr == CPU0_FORCE_0_7_OFS && wr_data[0]
		&& enable_q[0] && !(wr_en && hit_en) |=> ##1 irq_cpu0_q)
		else $error("forced event gave no interrupt");

	// interrupt follows enabled raw events of pins 0-7 or forced events
	a_irq_cause: assert property (irq_cpu0_q ==
		$past(|(enable_q & ((events[31:0]) | force_q))))
		else $error("interrupt disagrees with events");

	// read of the pins 0-7 word returns it next cycle
	a_raw0_read: assert property (rd_en && addr == RAW_PINS_0_7_OFS |=>
		rd_data_q == $past(raw0))
		else $error("pins 0-7 word read wrong");

	// read of the enable word returns it next cycle
	a_enable_read: assert property (rd_en && addr == CPU0_ENABLE_0_7_OFS |=>
		rd_data_q == $past(enable_q))
		else $error("enable word read wrong");

	// read of the force word returns it next cycle
	a_force_read: assert property (rd_en && addr == CPU0_FORCE_0_7_OFS |=>
		rd_data_q == $past(force_q))
		else $error("force word read wrong");

	// unmapped addresses read as zero
	a_unmapped_read: assert property (rd_en && !(hit_raw0 || hit_raw1 || hit_raw2
		|| hit_raw3 || hit_en || hit_frc) |=> rd_data_q == 32'h0)
		else $error("unmapped read not zero");

	// read data drop to zero when no read was made
	a_rdata_idle: assert property (!rd_en |=>
		rd_data_q == 32'h0)
		else $error("read data stand without a read");

	// force word takes a whole write
	a_force_write: assert property (wr_en && addr == CPU0_FORCE_0_7_OFS |=>
		force_q == $past(wr_data))
		else $error("force word did not store");

	// enable word keeps its value without a write
	a_enable_hold: assert property (!(wr_en && addr == CPU0_ENABLE_0_7_OFS) |=>
		enable_q == $past(enable_q))
		else $error("enable word changed without write");

	// force word keeps its value without a write
	a_force_hold: assert property (!(wr_en && addr == CPU0_FORCE_0_7_OFS) |=>
		force_q == $past(force_q))
		else $error("force word changed without write");

	// falling pin 8 shows in bit 2 of its nibble
	a_raw1_fall: assert property (pin_level[8] ##1 !pin_level[8] |=>
		raw1[2])
		else $error("pin 8 fall not in bit 2");

	// falling pin 16 shows in the lowest nibble of its word
	a_raw2_fall: assert property (pin_level[16] ##1 !pin_level[16] |=>
		raw2[2])
		else $error("pin 16 fall not seen");

	// rising pin 23 shows in the top nibble of its word
	a_raw2_rise: assert property (!pin_level[23] ##1 pin_level[23] |=>
		raw2[31])
		else $error("pin 23 rise not seen");

	// rising pin 29 shows in bit 23 of the last word
	a_raw3_rise: assert property (!pin_level[29] ##1 pin_level[29] |=>
		raw3[23])
		else $error("pin 29 rise not seen");

	// falling pin 0 shows in bit 2 of the first word
	a_raw0_fall: assert property (pin_level[0] ##1 !pin_level[0] |=>
		raw0[2])
		else $error("pin 0 fall not seen");

	// level bits of pin 29 follow the pad
	a_raw3_level: assert property (raw3[21] == pin_level[29]
		&& raw3[20] == !pin_level[29])
		else $error("pin 29 level bits wrong");

	// level bits of pin 0 follow the pad
	a_raw0_level: assert property (raw0[1] == pin_level[0]
		&& raw0[0] == !pin_level[0])
		else $error("pin 0 level bits wrong");

	// writing one clears pin 9 rise when no new rise arrives
	a_raw1_clear: assert property (wr_en && hit_raw1 && wr_data[7]
		&& !(pin_level[9] && !$past(pin_level[9])) |=> !raw1[7])
		else $error("pin 9 rise not cleared");

	// writing one clears pin 29 fall when no new fall arrives
	a_raw3_clear: assert property (wr_en && hit_raw3 && wr_data[22]
		&& !(!pin_level[29] && $past(pin_level[29])) |=> !raw3[22])
		else $error("pin 29 fall not cleared");

	// writing one clears pin 0 fall when no new fall arrives
	a_raw0_clear: assert property (wr_en && hit_raw0 && wr_data[2]
		&& !(!pin_level[0] && $past(pin_level[0])) |=> !raw0[2])
		else $error("pin 0 fall not cleared");

	// nothing enabled, no interrupt
	a_irq_off: assert property (enable_q == 32'h0 |=>
		!irq_cpu0_q)
		else $error("interrupt with nothing enabled");

	// enabled high level of pin 0 raises the interrupt
	a_irq_raw: assert property (enable_q[1] && pin_level[0] |=>
		irq_cpu0_q)
		else $error("enabled level gave no interrupt");

	// any enabled forced bit raises the interrupt
	a_irq_force: assert property (|(enable_q & force_q) |=>
		irq_cpu0_q)
		else $error("enabled force gave no interrupt");
endmodule // gpio_irq_status_enable

// ===== rtl/pin_event_detect.sv
`timescale 1ns/1ps
module pin_event_detect #(
	parameter int PINS = 30
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// pad levels and clear requests
	input wire logic [PINS-1:0] pin_level,
	input wire logic [4*PINS-1:0] edge_clr,
	// packed nibbles, rise/fall/high/low per pin
	output logic [4*PINS-1:0] events
);
	import pin_event_pkg::*;

	logic [PINS-1:0] prev_q; // level seen last cycle
	logic armed_q; // no edge until one sample exists
	logic [PINS-1:0] rise_q; // sticky rising edges
	logic [PINS-1:0] fall_q; // sticky falling edges
	logic [PINS-1:0] rise_d;
	logic [PINS-1:0] fall_d;
	logic [PINS-1:0] clr_rise;
	logic [PINS-1:0] clr_fall;

	// pick the clear bits out of the nibbles, pack status back in
	always_comb begin
		for (int p = 0; p < PINS; p++) begin
			clr_rise[p] = edge_clr[EVT_BITS*p+NIB_RISE];
			clr_fall[p] = edge_clr[EVT_BITS*p+NIB_FALL];
			events[EVT_BITS*p+NIB_RISE] = rise_q[p];
			events[EVT_BITS*p+NIB_FALL] = fall_q[p];
			events[EVT_BITS*p+NIB_HIGH] = pin_level[p];
			events[EVT_BITS*p+NIB_LOW] = ~pin_level[p];
		end
	end

	// a new edge wins over a clear in the same cycle
	assign rise_d = (rise_q & ~clr_rise) | ({PINS{armed_q}} & pin_level & ~prev_q);
	assign fall_d = (fall_q & ~clr_fall) | ({PINS{armed_q}} & ~pin_level & prev_q);

	// edge history and sticky flags
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prev_q <= '0;
			armed_q <= 1'b0;
			rise_q <= '0;
			fall_q <= '0;
		end else begin
			prev_q <= pin_level;
			armed_q <= 1'b1;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end
endmodule // pin_event_detect

// ===== rtl/pin_event_pkg.sv
package pin_event_pkg;
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PIN_COUNT = 30;
	localparam int EVT_BITS = 4;
	// register byte offsets
	localparam logic [ADDR_W-1:0] RAW_PINS_0_7_OFS = 12'h0f0;
	localparam logic [ADDR_W-1:0] RAW_PINS_8_15_OFS = 12'h0f4;
	localparam logic [ADDR_W-1:0] RAW_PINS_16_23_OFS = 12'h0f8;
	localparam logic [ADDR_W-1:0] RAW_PINS_24_29_OFS = 12'h0fc;
	localparam logic [ADDR_W-1:0] CPU0_ENABLE_0_7_OFS = 12'h100;
	localparam logic [ADDR_W-1:0] CPU0_FORCE_0_7_OFS = 12'h110;
	// bit positions inside one pin nibble
	localparam int NIB_RISE = 3;
	localparam int NIB_FALL = 2;
	localparam int NIB_HIGH = 1;
	localparam int NIB_LOW = 0;
	// edge bits of every nibble, the only clearable ones
	localparam logic [DATA_W-1:0] EDGE_BITS_MASK = 32'hcccccccc;
	// live bits of the last raw word, 31:24 read as zero
	localparam logic [DATA_W-1:0] RAW_LAST_MASK = 32'h00ffffff;
	// reset values
	localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] FORCE_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
endpackage

// ===== testbench/pad_model.sv
`timescale 1ns/1ps
module pad_model (
	// clock
	input wire logic clk_sys,
	// pad levels wanted by the bench
	input wire logic [29:0] want,
	// pad levels seen by the block
	output logic [29:0] pin_level
);
	// pads change on a clock edge, as synchronous inputs
	// first edge lands inside reset, so no edge is seen at release
	always @(posedge clk_sys) begin
		pin_level <= want;
	end
endmodule // pad_model

// ===== testbench/test_gpio_irq_status_enable.sv
`timescale 1ns/1ps
module test_gpio_irq_status_enable;
	import pin_event_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] addr = 12'h000;
	logic [DATA_W-1:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data_q;
	logic irq_cpu0_q;
	logic [PIN_COUNT-1:0] pin_level;
	// pad levels and edge history kept by the bench
	logic [PIN_COUNT-1:0] want = 30'h0;
	logic [PIN_COUNT-1:0] rise_s = 30'h0;
	logic [PIN_COUNT-1:0] fall_s = 30'h0;
	int errors = 0;
	int compares = 0;
	always #5 clk_sys = ~clk_sys;
	gpio_irq_status_enable dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
		.pin_level(pin_level), .irq_cpu0_q(irq_cpu0_q));
	pad_model pads (.clk_sys(clk_sys), .want(want), .pin_level(pin_level));
	// compare and count
	task check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one-cycle write strobe
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	// one-cycle read strobe, data taken in the next cycle
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		check("rd_data_q", rd_data_q, exp);
	endtask
	// expected raw word k from pad history
	function automatic logic [DATA_W-1:0] raw_exp(input int k);
		logic [DATA_W-1:0] w;
		int p;
		w = 32'h0;
		for (int i = 0; i < 8; i++) begin
			p = 8 * k + i;
			if (p < PIN_COUNT) w[4*i+:4] = {rise_s[p], fall_s[p], want[p], ~want[p]};
		end
		return w;
	endfunction
	// drive pads and note the edges they make
	task set_pads(input logic [PIN_COUNT-1:0] v);
		@(posedge clk_sys);
		rise_s = rise_s | (v & ~want);
		fall_s = fall_s | (~v & want);
		want <= v;
		repeat (4) @(posedge clk_sys);
	endtask
	// all four raw words, one idle cycle between reads
	task check_raw;
		for (int k = 0; k < 4; k++) begin
			rd(RAW_PINS_0_7_OFS + 12'(4 * k), raw_exp(k));
		end
	endtask
	// interrupt two edges after its cause
	task irq_after(input logic e);
		repeat (2) @(posedge clk_sys);
		#1;
		check("irq_cpu0_q", {31'h0, irq_cpu0_q}, {31'h0, e});
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		#100000;
		errors++;
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		rd(CPU0_ENABLE_0_7_OFS, 32'h0);
		rd(CPU0_FORCE_0_7_OFS, 32'h0);
		check_raw;
		irq_after(1'b0);
		$display("test reset done");
		set_pads(30'h2aaaaaaa);
		check_raw;
		set_pads(30'h3fffffff);
		check_raw;
		set_pads(30'h15555555);
		check_raw;
		wr(RAW_PINS_8_15_OFS, 32'h88888888);
		rise_s[15:8] = 8'h00;
		check_raw;
		for (int k = 0; k < 4; k++) wr(RAW_PINS_0_7_OFS + 12'(4 * k), 32'hffffffff);
		rise_s = 30'h0;
		fall_s = 30'h0;
		check_raw;
		$display("test edges done");
		wr(CPU0_ENABLE_0_7_OFS, 32'ha5c30f96);
		wr(CPU0_FORCE_0_7_OFS, 32'h5a3cf069);
		wr(12'h104, 32'hffffffff);
		rd(CPU0_ENABLE_0_7_OFS, 32'ha5c30f96);
		rd(CPU0_FORCE_0_7_OFS, 32'h5a3cf069);
		rd(12'h104, 32'h0);
		$display("test words done");
		wr(CPU0_FORCE_0_7_OFS, 32'h0);
		wr(CPU0_ENABLE_0_7_OFS, 32'h0);
		irq_after(1'b0);
		wr(CPU0_ENABLE_0_7_OFS, 32'h2);
		irq_after(1'b1);
		wr(CPU0_ENABLE_0_7_OFS, 32'h1);
		irq_after(1'b0);
		wr(CPU0_FORCE_0_7_OFS, 32'h1);
		irq_after(1'b1);
		wr(CPU0_FORCE_0_7_OFS, 32'h0);
		wr(CPU0_ENABLE_0_7_OFS, 32'h4);
		irq_after(1'b0);
		set_pads(30'h0);
		irq_after(1'b1);
		wr(RAW_PINS_0_7_OFS, 32'h4);
		irq_after(1'b0);
		$display("test interrupt done");
		end_of_test;
	end
endmodule // test_gpio_irq_status_enable
